/* File: aad_defines.svh */
`ifndef AAD_DEFINES_SVH
`define AAD_DEFINES_SVH

// channel and selector geometry
`define AAD_NUM_CH      5
`define AAD_SEL_W       3
`define AAD_SIG_SW_W    8
`define AAD_GND_SW_W    7
`define AAD_GND_VREF    3'h6
`define AAD_GND_RSVD    3'h7

// decimation chain
`define AAD_S1_LAST     4'hf
`define AAD_S1_TICKS    5'h10
`define AAD_S2_LAST     3'h7
`define AAD_S2_INPUTS   4'h8
`define AAD_GAIN_Q      14'h1bf8
`define AAD_GAIN_FRAC   12
`define AAD_DC_SHIFT    10

// timing
`define AAD_CLK_HZ      20000000
`define AAD_FS_MAX_HZ   55000
`define AAD_MIN_GAP     ((`AAD_CLK_HZ + `AAD_FS_MAX_HZ - 1) / `AAD_FS_MAX_HZ)
`define AAD_GAP_W       10

// reset values
`define AAD_SMP_RST     24'h000000

`endif

/* File: aad_pkg.sv */
`include "aad_defines.svh"

package aad_pkg;

    typedef logic signed [13:0] aad_s1_t;
    typedef logic signed [24:0] aad_s2_t;
    typedef logic signed [23:0] aad_smp_t;
    typedef logic signed [39:0] aad_wide_t;

    // clamp a wide value into a 24-bit sample
    function automatic aad_smp_t aad_sat24(input aad_wide_t x);
        if (x > 40'sh00007fffff) begin
            return 24'h7fffff;
        end else if (x < -40'sh0000800000) begin
            return 24'h800000;
        end else begin
            return x[23:0];
        end
    endfunction

    // one-hot decode of a 3-bit selector code
    function automatic logic [7:0] aad_onehot8(input logic [2:0] code);
        return 8'h01 << code;
    endfunction

endpackage

/* File: aad_dc_block.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aad_defines.svh"

module aad_dc_block
    import aad_pkg::*;
(
    input  wire logic     sys_clk_i,
    input  wire logic     rst_b_i,
    input  wire logic     dc_en_i,
    input  wire logic     in_vld_i,
    input  wire aad_smp_t in_smp_i,
    output logic          out_vld_o,
    output aad_smp_t      out_smp_o
);

    // power-up value of the history only, no reset clears it later
    logic signed [25:0] x1_reg = 26'sh0000000;
    logic signed [25:0] y1_reg = 26'sh0000000;
    logic signed [25:0] y_next;
    logic               out_vld_reg;
    aad_smp_t           out_smp_reg;

    // first-order high-pass, pole just inside the unit circle
    always_comb begin
        y_next = 26'(in_smp_i) - x1_reg + y1_reg - (y1_reg >>> `AAD_DC_SHIFT);
    end

    // filter history, deliberately left without reset
    always_ff @(posedge sys_clk_i) begin
        if (in_vld_i) begin
            x1_reg <= 26'(in_smp_i);
            y1_reg <= dc_en_i ? y_next : 26'sh0;
        end
    end

    // output sample, filtered or passed straight
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            out_vld_reg <= 1'b0;
            out_smp_reg <= `AAD_SMP_RST;
        end else begin
            out_vld_reg <= in_vld_i;
            if (in_vld_i) begin
                out_smp_reg <= dc_en_i ? aad_sat24(40'(y_next)) : in_smp_i;
            end
        end
    end

    assign out_vld_o = out_vld_reg;
    assign out_smp_o = out_smp_reg;

    dc_bypass_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (in_vld_i && !dc_en_i) |=> (out_vld_o && out_smp_o == $past(in_smp_i)))
        else $error("dc bypass did not pass sample unchanged");

endmodule

`default_nettype wire

/* File: aad_input_decimator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aad_defines.svh"

// Functional notes
// - per-channel 3-bit signal source select decode
// - ground select: pins, mid-supply, 111 reserved
// - any input routes to any channel
// - output sample rate capped at 55 kHz
// - channels paired for stereo output, ch4 left with a zero right
// - 1-bit third-order modulator stream at 128 fs
// - first stage CIC decimates by 16
// - reformat stage-one words for stage two
// - second stage decimates by 8 to fs
// - passband chain gain of 4.85 dB
// - DC-removal filter switched by one bit
// - filter state set at power-up only, no reset clears it

module aad_input_decimator
    import aad_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        mod_clk_i,
    input  wire logic [4:0]  mod_bit_i,
    input  wire logic [14:0] sig_sel_i,
    input  wire logic [14:0] gnd_sel_i,
    input  wire logic        dc_block_en_i,
    output logic      [39:0] sig_switch_o,
    output logic      [34:0] gnd_switch_o,
    output logic             gnd_rsvd_o,
    output logic      [71:0] pair_left_o,
    output logic      [71:0] pair_right_o,
    output logic             pair_valid_o,
    output logic             rate_over_o
);

    localparam int           NCH       = `AAD_NUM_CH;
    localparam logic [9:0]   MIN_GAP_M1 = 10'(`AAD_MIN_GAP - 1);
    localparam logic signed [13:0] GAIN = `AAD_GAIN_Q;

    logic        mclk_s1_reg, mclk_s2_reg, mclk_s3_reg;
    logic [4:0]  mbit_s1_reg, mbit_s2_reg;
    logic        tick;
    logic [39:0] sig_switch_reg;
    logic [34:0] gnd_switch_reg;
    logic        gnd_rsvd_reg;
    logic [3:0]  s1_cnt_reg;
    logic        s1_fire;
    logic        s1_vld_reg;
    // power-up value of the filter state only, no reset clears it later
    aad_s1_t     s1_i1_reg [NCH] = '{default: '0};
    aad_s1_t     s1_i2_reg [NCH] = '{default: '0};
    aad_s1_t     s1_i3_reg [NCH] = '{default: '0};
    aad_s1_t     s1_d1_reg [NCH] = '{default: '0};
    aad_s1_t     s1_d2_reg [NCH] = '{default: '0};
    aad_s1_t     s1_d3_reg [NCH] = '{default: '0};
    aad_s1_t     s1_c1 [NCH];
    aad_s1_t     s1_c2 [NCH];
    aad_s1_t     s1_c3 [NCH];
    aad_s2_t     s1_out_reg [NCH] = '{default: '0};
    logic [2:0]  s2_cnt_reg;
    logic        s2_fire;
    aad_s2_t     s2_i1_reg [NCH] = '{default: '0};
    aad_s2_t     s2_i2_reg [NCH] = '{default: '0};
    aad_s2_t     s2_i3_reg [NCH] = '{default: '0};
    aad_s2_t     s2_d1_reg [NCH] = '{default: '0};
    aad_s2_t     s2_d2_reg [NCH] = '{default: '0};
    aad_s2_t     s2_d3_reg [NCH] = '{default: '0};
    aad_s2_t     s2_c1 [NCH];
    aad_s2_t     s2_c2 [NCH];
    aad_s2_t     s2_c3 [NCH];
    logic signed [38:0] s2_prod [NCH];
    logic        g_vld_reg;
    aad_smp_t    g_smp_reg [NCH] = '{default: '0};
    logic [NCH-1:0] dc_vld;
    aad_smp_t    dc_smp [NCH];
    logic [9:0]  gap_cnt_reg;
    logic        rate_ok;
    logic [71:0] pair_left_reg;
    logic [71:0] pair_right_reg;
    logic        pair_valid_reg;
    logic        rate_over_reg;
    logic [4:0]  hlp_tick_reg;
    logic [3:0]  hlp_s1_reg;

    ////////////////////////////////////////////////////////////////////////////
    // modulator pins: two-flop synchronisers, edge taken after the second
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            mclk_s1_reg <= 1'b0;
            mclk_s2_reg <= 1'b0;
            mclk_s3_reg <= 1'b0;
            mbit_s1_reg <= 5'h00;
            mbit_s2_reg <= 5'h00;
        end else begin
            mclk_s1_reg <= mod_clk_i;
            mclk_s2_reg <= mclk_s1_reg;
            mclk_s3_reg <= mclk_s2_reg;
            mbit_s1_reg <= mod_bit_i;
            mbit_s2_reg <= mbit_s1_reg;
        end
    end

    // one tick per 128 fs modulator period
    assign tick = mclk_s2_reg & ~mclk_s3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // source switch matrix drive, each channel decoded on its own
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sig_switch_reg <= 40'h0;
            gnd_switch_reg <= 35'h0;
            gnd_rsvd_reg   <= 1'b0;
        end else begin
            gnd_rsvd_reg <= 1'b0;
            for (int c = 0; c < NCH; c++) begin
                sig_switch_reg[c*8 +: 8] <= aad_onehot8(sig_sel_i[c*3 +: 3]);
                // code 111 sets bit 7, which is dropped: no ground switch closes
                gnd_switch_reg[c*7 +: 7] <= 7'(aad_onehot8(gnd_sel_i[c*3 +: 3]));
                if (gnd_sel_i[c*3 +: 3] == `AAD_GND_RSVD) begin
                    gnd_rsvd_reg <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stage one: third-order CIC on the 1-bit stream
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s1_cnt_reg <= 4'h0;
        end else if (tick) begin
            s1_cnt_reg <= s1_cnt_reg + 4'h1;
        end
    end

    assign s1_fire = tick && (s1_cnt_reg == `AAD_S1_LAST);

    // comb section at 8 fs
    always_comb begin
        for (int l = 0; l < NCH; l++) begin
            s1_c1[l] = s1_i3_reg[l] - s1_d1_reg[l];
            s1_c2[l] = s1_c1[l] - s1_d2_reg[l];
            s1_c3[l] = s1_c2[l] - s1_d3_reg[l];
        end
    end

    // integrators and comb delays, no reset on filter state
    always_ff @(posedge sys_clk_i) begin
        for (int l = 0; l < NCH; l++) begin
            if (tick) begin
                s1_i1_reg[l] <= s1_i1_reg[l] + (mbit_s2_reg[l] ? 14'sh0001 : -14'sh0001);
                s1_i2_reg[l] <= s1_i2_reg[l] + s1_i1_reg[l];
                s1_i3_reg[l] <= s1_i3_reg[l] + s1_i2_reg[l];
            end
            if (s1_fire) begin
                s1_d1_reg[l]  <= s1_i3_reg[l];
                s1_d2_reg[l]  <= s1_c1[l];
                s1_d3_reg[l]  <= s1_c2[l];
                // rework to the stage-two word: sign-extend, two guard bits
                s1_out_reg[l] <= {{9{s1_c3[l][13]}}, s1_c3[l], 2'b00};
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s1_vld_reg <= 1'b0;
        end else begin
            s1_vld_reg <= s1_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stage two: third-order CIC decimating by 8 to fs
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s2_cnt_reg <= 3'h0;
        end else if (s1_vld_reg) begin
            s2_cnt_reg <= s2_cnt_reg + 3'h1;
        end
    end

    assign s2_fire = s1_vld_reg && (s2_cnt_reg == `AAD_S2_LAST);

    // combs plus fixed gain trim
    always_comb begin
        for (int l = 0; l < NCH; l++) begin
            s2_c1[l]   = s2_i3_reg[l] - s2_d1_reg[l];
            s2_c2[l]   = s2_c1[l] - s2_d2_reg[l];
            s2_c3[l]   = s2_c2[l] - s2_d3_reg[l];
            s2_prod[l] = s2_c3[l] * GAIN;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int l = 0; l < NCH; l++) begin
            if (s1_vld_reg) begin
                s2_i1_reg[l] <= s2_i1_reg[l] + s1_out_reg[l];
                s2_i2_reg[l] <= s2_i2_reg[l] + s2_i1_reg[l];
                s2_i3_reg[l] <= s2_i3_reg[l] + s2_i2_reg[l];
            end
            if (s2_fire) begin
                s2_d1_reg[l] <= s2_i3_reg[l];
                s2_d2_reg[l] <= s2_c1[l];
                s2_d3_reg[l] <= s2_c2[l];
                g_smp_reg[l] <= aad_sat24(40'(s2_prod[l] >>> `AAD_GAIN_FRAC));
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            g_vld_reg <= 1'b0;
        end else begin
            g_vld_reg <= s2_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switchable DC removal, one per channel
    for (genvar l = 0; l < NCH; l++) begin : g_dc
        aad_dc_block u_dc (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .dc_en_i   (dc_block_en_i),
            .in_vld_i  (g_vld_reg),
            .in_smp_i  (g_smp_reg[l]),
            .out_vld_o (dc_vld[l]),
            .out_smp_o (dc_smp[l])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // rate guard: samples closer than the 55 kHz period are dropped
    assign rate_ok = (gap_cnt_reg >= MIN_GAP_M1);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            gap_cnt_reg   <= 10'h3ff;
            rate_over_reg <= 1'b0;
        end else if (dc_vld[0]) begin
            gap_cnt_reg   <= rate_ok ? 10'h000 : gap_cnt_reg + 10'h001;
            rate_over_reg <= !rate_ok;
        end else if (gap_cnt_reg != 10'h3ff) begin
            gap_cnt_reg <= gap_cnt_reg + 10'h001;
        end
    end

    // stereo pair outputs: pair p is channel 2p left, 2p+1 right; pair 2 is ch4 left, zero right
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pair_left_reg  <= 72'h0;
            pair_right_reg <= 72'h0;
            pair_valid_reg <= 1'b0;
        end else begin
            pair_valid_reg <= dc_vld[0] && rate_ok;
            if (dc_vld[0] && rate_ok) begin
                pair_left_reg  <= {dc_smp[4], dc_smp[2], dc_smp[0]};
                pair_right_reg <= {`AAD_SMP_RST, dc_smp[3], dc_smp[1]};
            end
        end
    end

    assign sig_switch_o = sig_switch_reg;
    assign gnd_switch_o = gnd_switch_reg;
    assign gnd_rsvd_o   = gnd_rsvd_reg;
    assign pair_left_o  = pair_left_reg;
    assign pair_right_o = pair_right_reg;
    assign pair_valid_o = pair_valid_reg;
    assign rate_over_o  = rate_over_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checking helpers: ticks per stage-one word, words per fs sample
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            hlp_tick_reg <= 5'h00;
            hlp_s1_reg   <= 4'h0;
        end else begin
            if (s1_vld_reg) begin
                hlp_tick_reg <= {4'h0, tick};
            end else if (tick) begin
                hlp_tick_reg <= hlp_tick_reg + 5'h01;
            end
            if (g_vld_reg) begin
                hlp_s1_reg <= {3'h0, s1_vld_reg};
            end else if (s1_vld_reg) begin
                hlp_s1_reg <= hlp_s1_reg + 4'h1;
            end
        end
    end

    sig_decode_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        1'b1 |=> sig_switch_o[7:0] == (8'h01 << $past(sig_sel_i[2:0])))
        else $error("signal switch does not follow selector");

    sel_indep_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ($stable(sig_sel_i[14:12]) && $changed(sig_sel_i[2:0])) |=> $stable(sig_switch_o[39:32]))
        else $error("channel four switch moved with channel zero select");

    gnd_rsvd_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (gnd_sel_i[2:0] == `AAD_GND_RSVD) |=> (gnd_switch_o[6:0] == 7'h00 && gnd_rsvd_o))
        else $error("reserved ground code closed a switch");

    gnd_vref_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (gnd_sel_i[5:3] == `AAD_GND_VREF) |=> (gnd_switch_o[13:7] == 7'h40))
        else $error("mid-supply ground code not decoded");

    s1_ratio_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s1_vld_reg |-> (hlp_tick_reg == `AAD_S1_TICKS))
        else $error("stage one word not every 16 modulator ticks");

    s2_ratio_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        g_vld_reg |-> (hlp_s1_reg == `AAD_S2_INPUTS))
        else $error("fs sample not every 8 stage one words");

    reform_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s1_vld_reg |-> (s1_out_reg[0][1:0] == 2'b00 && s1_out_reg[0][24] == s1_out_reg[0][15]))
        else $error("stage one word not reworked for stage two");

    gain_full_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (s2_fire && s2_c3[3] == 25'sh0400000) |=> (g_smp_reg[3] == 24'h6fe000))
        else $error("passband gain trim wrong");

    valid_pulse_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        pair_valid_o |=> !pair_valid_o)
        else $error("pair valid longer than one cycle");

    rate_drop_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (dc_vld[0] && gap_cnt_reg < MIN_GAP_M1) |=> (!pair_valid_o && rate_over_o))
        else $error("sample above the rate cap was passed");

    pair_data_a : assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        pair_valid_o |-> (pair_left_o[23:0] == $past(dc_smp[0]) && pair_right_o[23:0] == $past(dc_smp[1])))
        else $error("stereo pair not taken together");

endmodule

`default_nettype wire

/* File: aad_mod_model.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// stand-in for five sigma-delta modulators: one tick clock, five 1-bit streams
////////////////////////////////////////////////////////////////////////////////

module aad_mod_model #(
    parameter int HALF = 2
) (
    input  wire logic        sys_clk_i,
    input  wire logic        run_i,
    input  wire logic [19:0] pattern_i,
    output logic             mod_clk_o,
    output logic      [4:0]  mod_bit_o
);

    logic [7:0] cnt_reg;
    logic [1:0] phase_reg;

    // tick clock: HALF cycles low then HALF high, stands still while idle
    always_ff @(posedge sys_clk_i) begin
        if (!run_i) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg == 8'(2 * HALF - 1)) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    assign mod_clk_o = run_i && (cnt_reg >= 8'(HALF));

    // one new bit per channel each tick, changed while the clock is low
    always_ff @(posedge sys_clk_i) begin
        if (!run_i) begin
            phase_reg <= 2'h0;
            mod_bit_o <= 5'h00;
        end else if (cnt_reg == 8'(2 * HALF - 1)) begin
            phase_reg <= phase_reg + 2'h1;
            for (int c = 0; c < 5; c++) begin
                mod_bit_o[c] <= pattern_i[4 * c + int'(phase_reg)];
            end
        end
    end

endmodule

`default_nettype wire

/* File: aad_input_decimator_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aad_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the input decimator
////////////////////////////////////////////////////////////////////////////////

module aad_input_decimator_test;

    localparam int HALF   = 2;
    localparam int FS_CYC = 128 * 2 * HALF;

    logic        sys_clk;
    logic        rst_b;
    logic [14:0] sig_sel;
    logic [14:0] gnd_sel;
    logic        dc_en;
    logic        run;
    logic [19:0] pattern;
    wire logic   mod_clk;
    wire logic [4:0] mod_bit;
    logic [39:0] sig_sw;
    logic [34:0] gnd_sw;
    logic        gnd_rsvd;
    logic [71:0] left_w;
    logic [71:0] right_w;
    logic        valid;
    logic        rate_over;
    int          n_errors;
    int          tests_run;
    int          gap;
    logic [2:0]  code;
    logic [39:0] exp_s;
    logic [34:0] exp_g;
    logic        exp_v;
    logic [23:0] pos_q;
    logic [71:0] exp_l;
    logic [71:0] exp_r;

    aad_mod_model #(.HALF(HALF)) modulators (
        .sys_clk_i (sys_clk),
        .run_i     (run),
        .pattern_i (pattern),
        .mod_clk_o (mod_clk),
        .mod_bit_o (mod_bit)
    );

    aad_input_decimator uut (
        .sys_clk_i     (sys_clk),
        .rst_b_i       (rst_b),
        .mod_clk_i     (mod_clk),
        .mod_bit_i     (mod_bit),
        .sig_sel_i     (sig_sel),
        .gnd_sel_i     (gnd_sel),
        .dc_block_en_i (dc_en),
        .sig_switch_o  (sig_sw),
        .gnd_switch_o  (gnd_sw),
        .gnd_rsvd_o    (gnd_rsvd),
        .pair_left_o   (left_w),
        .pair_right_o  (right_w),
        .pair_valid_o  (valid),
        .rate_over_o   (rate_over)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, 50 ns period
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // compare and count
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic results;
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // wait for the next pair strobe, counting falling edges
    task automatic wait_valid(output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (valid !== 1'b1 && n < 2000);
        if (n >= 2000) check(72'h0, 72'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog sized to nearly three times the expected run
    initial begin
        repeat (60 * FS_CYC) @(posedge sys_clk);
        n_errors++;
        results;
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b     = 1'b0;
        sig_sel   = 15'h0000;
        gnd_sel   = {5{3'h6}};
        dc_en     = 1'b0;
        run       = 1'b0;
        pattern   = 20'h00000;
        n_errors  = 0;
        tests_run = 0;
        pos_q     = 24'((40'h400000 * `AAD_GAIN_Q) >> `AAD_GAIN_FRAC);
        repeat (6) @(negedge sys_clk);
        rst_b = 1'b1;

        // every selector code on every channel, rotated per channel
        for (int k = 0; k < 8; k++) begin
            exp_v = 1'b0;
            for (int c = 0; c < 5; c++) begin
                code                = 3'(k + c);
                sig_sel[3 * c +: 3] = code;
                gnd_sel[3 * c +: 3] = code;
                exp_s[8 * c +: 8]   = 8'h01 << code;
                exp_g[7 * c +: 7]   = (code == 3'h7) ? 7'h00 : 7'h01 << code;
                exp_v               = exp_v | (code == 3'h7);
            end
            @(negedge sys_clk);
            check(72'(sig_sw), 72'(exp_s));
            check(72'(gnd_sw), 72'(exp_g));
            check(72'(gnd_rsvd), 72'(exp_v));
        end
        // only channel zero moves: the other switches must stay put
        sig_sel[2:0] = 3'h1;
        @(negedge sys_clk);
        check(72'(sig_sw), 72'({exp_s[39:8], 8'h02}));

        // legal routing: own ground on ch0, mid-supply elsewhere
        sig_sel = {3'h5, 3'h4, 3'h3, 3'h2, 3'h0};
        gnd_sel = {3'h6, 3'h6, 3'h6, 3'h6, 3'h0};
        // ch0 full +, ch1 full -, ch2 quarter ones, ch3 three quarters, ch4 zero mean
        pattern = {4'ha, 4'he, 4'h1, 4'h0, 4'hf};
        run     = 1'b1;
        exp_l   = {24'h000000, 24'(-pos_q), 24'h7fffff};
        exp_r   = {24'h000000, pos_q, 24'h800000};
        repeat (8) wait_valid(gap);
        check(left_w, exp_l);
        check(right_w, exp_r);
        wait_valid(gap);
        check(72'(gap), 72'(FS_CYC));
        @(negedge sys_clk);
        check(72'(valid), 72'h0);
        check(72'(rate_over), 72'h0);

        // dc removal in: a constant level is removed entirely
        dc_en = 1'b1;
        repeat (4) wait_valid(gap);
        check(left_w, 72'h0);
        wait_valid(gap);
        check(right_w, 72'h0);
        check(72'(gap), 72'(FS_CYC));

        // dc removal out: level back untouched
        dc_en = 1'b0;
        repeat (3) wait_valid(gap);
        check(left_w, exp_l);

        // reset in mid-stream, filters keep running afterwards
        rst_b = 1'b0;
        @(negedge sys_clk);
        check(72'(valid), 72'h0);
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        // counters restart out of step with the combs: let the transient pass
        repeat (5) wait_valid(gap);
        check(left_w, exp_l);
        check(right_w, exp_r);
        check(72'(rate_over), 72'h0);
        results;
    end

endmodule

`default_nettype wire
